// ===== src/iep_slave.sv
// memory device end: two-wire slave with paged nonvolatile rows and shadow copy
`timescale 1ns/1ps
`include "iep_regs.svh"
module iep_slave
    import iep_pkg::*;
#(
    parameter int NVW_CYCLES = `IEP_NVW_TIME_NS / `IEP_CLK_NS
) (
    input  wire logic  clk_i,
    input  wire logic  reset_n_i,
    iep_link_if.slave  link,
    output logic       busy_o,
    output logic       shadow_on_o,
    output logic       mask_on_o
);
    logic       scl_q1_ff, scl_q2_ff, scl_q3_ff;
    logic       sda_q1_ff, sda_q2_ff, sda_q3_ff;
    iep_sst_t   st_ff;
    iep_kind_t  kind_ff;
    iep_space_t space_ff;
    logic       rw_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shr_ff;
    logic [7:0] txs_ff;
    logic       oe_ff;
    logic       mnack_ff;
    logic [7:0] ptr_ff;
    logic [7:0] pg_ff [8];
    logic [7:0] touched_ff;
    logic       busy_ff;
    logic [31:0] busy_cnt_ff;
    logic       shadow_on_ff, mask_on_ff;
    // nonvolatile array has no reset: it keeps its contents over a reset
    logic [7:0] nv_mem [2048];
    logic [7:0] sh_mem [256];
    logic       sh_vld_ff [256];

    // edge and condition detection on the second and third sync stages only
    wire scl_rise  = scl_q2_ff & ~scl_q3_ff;
    wire scl_fall  = ~scl_q2_ff & scl_q3_ff;
    wire start_det = scl_q2_ff & scl_q3_ff & sda_q3_ff & ~sda_q2_ff;
    wire stop_det  = scl_q2_ff & scl_q3_ff & ~sda_q3_ff & sda_q2_ff;

    // slave address decode of the byte just shifted in
    wire [6:0] addr7   = shr_ff[7:1];
    wire       hit_aux = (addr7 == `IEP_ADDR_AUX);
    wire       hit_rx1 = (addr7 == `IEP_ADDR_RX1);
    wire       hit_rx2 = (addr7 == `IEP_ADDR_RX2);
    wire       hit_any = hit_aux | hit_rx1 | hit_rx2;
    wire       ack_adr = hit_any & ~busy_ff;

    // memory map: blocks of 128 bytes, receiver r uses blocks r*7 .. r*7+5
    wire       is_aux   = (space_ff == SP_AUX);
    wire       is_rx2   = (space_ff == SP_RX2);
    wire [3:0] base     = is_rx2 ? `IEP_RX2_BASE : 4'h0;
    wire       upper    = ptr_ff[7];
    wire [7:0] sidx     = {is_rx2, ptr_ff[6:0]};
    wire [7:0] tsel_sh  = sh_mem[{is_rx2, `IEP_TSEL_REG}];
    wire [7:0] tsel_nv  = nv_mem[{base, `IEP_TSEL_REG}];
    wire [7:0] tsel_b   = sh_vld_ff[{is_rx2, `IEP_TSEL_REG}] ? tsel_sh : tsel_nv;
    wire [2:0] tsel     = tsel_b[2:0];
    wire       tsel_ok  = (tsel_b <= `IEP_TSEL_MAX);
    wire       ena_row  = (ptr_ff[6:3] == `IEP_ENA_ROW);
    wire       is_t1    = (tsel == 3'h1);
    wire       is_t5    = (tsel == 3'h5);
    // table 05h borrows the enable row of table 01h while masking is on
    wire       map_empty = ~is_aux & upper &
                           (~tsel_ok | (is_t1 & ena_row & mask_on_ff) |
                            (is_t5 & ~(ena_row & mask_on_ff)));
    wire [2:0] tab_eff  = is_t5 ? 3'h1 : tsel;
    // table 04h is plain storage here, read and written like the other tables
    wire [3:0] blk_rx   = upper ? 4'(base + 4'h1 + {1'b0, tab_eff}) : base;
    wire [3:0] blk      = is_aux ? {`IEP_AUX_BLOCK, ptr_ff[7]} : blk_rx;
    wire [10:0] idx     = {blk, ptr_ff[6:0]};
    wire       shadowable = ~is_aux & ~upper;
    wire [7:0] rd_byte  = map_empty ? `IEP_EMPTY_BYTE :
                          (shadowable & sh_vld_ff[sidx]) ? sh_mem[sidx] : nv_mem[idx];

    // configuration bits come from receiver-1 table 02h only
    wire [7:0] cfg_sh   = nv_mem[{`IEP_CFG_BLOCK, `IEP_SHADOW_REG}];
    wire [7:0] cfg_mk   = nv_mem[{`IEP_CFG_BLOCK, `IEP_MASK_REG}];

    wire commit    = (start_det | stop_det) & (|touched_ff) & ~map_empty;
    wire to_shadow = shadowable & shadow_on_ff;
    wire nv_write  = commit & ~to_shadow;
    wire load_tx   = scl_fall & ((st_ff == S_SACK & rw_ff) | (st_ff == S_MACK & ~mnack_ff));
    wire byte_done = (st_ff == S_RECV) & scl_fall & (cnt_ff == 4'h8);
    wire [2:0] nxt_col = 3'(ptr_ff[2:0] + 3'h1);

    assign link.sda_s_o  = 1'b0;
    assign link.sda_s_oe = oe_ff;
    assign busy_o        = busy_ff;
    assign shadow_on_o   = shadow_on_ff;
    assign mask_on_o     = mask_on_ff;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_q1_ff <= 1'b1;
            scl_q2_ff <= 1'b1;
            scl_q3_ff <= 1'b1;
            sda_q1_ff <= 1'b1;
            sda_q2_ff <= 1'b1;
            sda_q3_ff <= 1'b1;
            shadow_on_ff <= 1'b0;
            mask_on_ff   <= 1'b0;
        end else begin
            scl_q1_ff <= link.scl;
            scl_q2_ff <= scl_q1_ff;
            scl_q3_ff <= scl_q2_ff;
            sda_q1_ff <= link.sda;
            sda_q2_ff <= sda_q1_ff;
            sda_q3_ff <= sda_q2_ff;
            shadow_on_ff <= cfg_sh[`IEP_SHADOW_BIT];
            mask_on_ff   <= cfg_mk[`IEP_MASK_BIT];
        end
    end

    // bit and byte sequencer; the device acts on the synchronised scl edges
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff      <= S_IDLE;
            kind_ff    <= K_SADDR;
            space_ff   <= SP_AUX;
            rw_ff      <= 1'b0;
            cnt_ff     <= 4'h0;
            shr_ff     <= 8'h00;
            txs_ff     <= 8'h00;
            oe_ff      <= 1'b0;
            mnack_ff   <= 1'b1;
            ptr_ff     <= 8'h00;
            touched_ff <= 8'h00;
        end else if (start_det) begin
            st_ff      <= S_RECV;
            kind_ff    <= K_SADDR;
            cnt_ff     <= 4'h0;
            oe_ff      <= 1'b0;
            touched_ff <= 8'h00;
        end else if (stop_det) begin
            st_ff      <= S_IDLE;
            oe_ff      <= 1'b0;
            touched_ff <= 8'h00;
        end else begin
            case (st_ff)
                S_RECV: begin
                    if (scl_rise) begin
                        shr_ff <= {shr_ff[6:0], sda_q2_ff};
                        cnt_ff <= 4'(cnt_ff + 4'h1);
                    end else if (byte_done) begin
                        cnt_ff <= 4'h0;
                        case (kind_ff)
                            K_SADDR: begin
                                if (ack_adr) begin
                                    oe_ff    <= 1'b1;
                                    rw_ff    <= shr_ff[0];
                                    space_ff <= hit_aux ? SP_AUX : hit_rx1 ? SP_RX1 : SP_RX2;
                                    kind_ff  <= K_MADDR;
                                    st_ff    <= S_SACK;
                                end else begin
                                    st_ff    <= S_IDLE;
                                end
                            end
                            K_MADDR: begin
                                ptr_ff  <= shr_ff;
                                kind_ff <= K_DATA;
                                oe_ff   <= 1'b1;
                                st_ff   <= S_SACK;
                            end
                            default: begin
                                touched_ff[ptr_ff[2:0]] <= 1'b1;
                                ptr_ff  <= {ptr_ff[7:3], nxt_col};
                                oe_ff   <= 1'b1;
                                st_ff   <= S_SACK;
                            end
                        endcase
                    end
                end
                S_SACK: begin
                    if (scl_fall && !rw_ff) begin
                        oe_ff <= 1'b0;
                        st_ff <= S_RECV;
                    end
                end
                S_SEND: begin
                    if (scl_fall) begin
                        if (cnt_ff == 4'h8) begin
                            oe_ff <= 1'b0;
                            st_ff <= S_MACK;
                        end else begin
                            oe_ff  <= ~txs_ff[6];
                            txs_ff <= {txs_ff[6:0], 1'b0};
                            cnt_ff <= 4'(cnt_ff + 4'h1);
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        mnack_ff <= sda_q2_ff;
                    end else if (scl_fall && mnack_ff) begin
                        st_ff <= S_IDLE;
                    end
                end
                default: begin
                    oe_ff <= 1'b0;
                end
            endcase
            // first byte of a read, and every byte after a master ack
            if (load_tx) begin
                txs_ff <= rd_byte;
                oe_ff  <= ~rd_byte[7];
                ptr_ff <= 8'(ptr_ff + 8'h01);
                cnt_ff <= 4'h1;
                st_ff  <= S_SEND;
            end
        end
    end

    // page buffer holds the data bytes of the current row until the commit
    always_ff @(posedge clk_i) begin
        if (byte_done && kind_ff == K_DATA) begin
            pg_ff[ptr_ff[2:0]] <= shr_ff;
        end
    end

    // only touched columns rewritten; untouched columns keep their stored value
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 8; i++) begin
            if (commit && touched_ff[i]) begin
                if (to_shadow) begin
                    sh_mem[{is_rx2, ptr_ff[6:3], 3'(i)}] <= pg_ff[i];
                end else begin
                    nv_mem[{blk, ptr_ff[6:3], 3'(i)}] <= pg_ff[i];
                end
            end
        end
    end

    // shadow valid bits clear on reset, so power-on shows nonvolatile data
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int j = 0; j < 256; j++) begin
                sh_vld_ff[j] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (commit && shadowable && touched_ff[i]) begin
                    sh_vld_ff[{is_rx2, ptr_ff[6:3], 3'(i)}] <= to_shadow;
                end
            end
        end
    end

    // commit timer; a shadow write skips it entirely
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_ff     <= 1'b0;
            busy_cnt_ff <= 32'h0;
        end else if (nv_write) begin
            busy_ff     <= 1'b1;
            busy_cnt_ff <= 32'h0;
        end else if (busy_ff) begin
            if (busy_cnt_ff == 32'(NVW_CYCLES - 1)) begin
                busy_ff <= 1'b0;
            end else begin
                busy_cnt_ff <= 32'(busy_cnt_ff + 32'h1);
            end
        end
    end
endmodule

// ===== src/iep_regs.svh
// offsets, field positions and timing counts of the paged two-wire memory
`ifndef IEP_REGS_SVH
`define IEP_REGS_SVH

`define IEP_ADDR_AUX    7'h50
`define IEP_ADDR_RX1    7'h51
`define IEP_ADDR_RX2    7'h59
`define IEP_TSEL_REG    7'h7F
`define IEP_SHADOW_REG  7'h00
`define IEP_SHADOW_BIT  0
`define IEP_MASK_REG    7'h08
`define IEP_MASK_BIT    0
`define IEP_ENA_ROW     4'hF
`define IEP_TSEL_MAX    8'h05
`define IEP_EMPTY_BYTE  8'h00
`define IEP_CFG_BLOCK   4'h3
`define IEP_AUX_BLOCK   3'h7
`define IEP_RX2_BASE    4'h7
`define IEP_CLK_NS      40
`define IEP_NVW_TIME_NS 10000000
`define IEP_SCL_QUARTER 4

`endif

// ===== src/iep_pkg.sv
// types shared by both ends of the paged two-wire memory link
package iep_pkg;
    typedef enum logic [2:0] {S_IDLE, S_RECV, S_SACK, S_SEND, S_MACK} iep_sst_t;
    typedef enum logic [1:0] {K_SADDR, K_MADDR, K_DATA} iep_kind_t;
    typedef enum logic [1:0] {SP_AUX, SP_RX1, SP_RX2} iep_space_t;
    typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} iep_mst_t;
    typedef enum logic [1:0] {C_START, C_STOP, C_WRITE, C_READ} iep_cmd_t;
endpackage

// ===== src/iep_link_if.sv
// two-wire link between the bus master and the memory device
`timescale 1ns/1ps
interface iep_link_if;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic sda;

    // wired-and with pull-up: any enabled driver with a low value pulls the line
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

    modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
    modport slave  (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface

// ===== src/iep_master.sv
// bus master end: byte-level two-wire master driving scl from a divider
`timescale 1ns/1ps
`include "iep_regs.svh"
module iep_master
    import iep_pkg::*;
#(
    parameter int QUARTER = `IEP_SCL_QUARTER
) (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    iep_link_if.master      link,
    input  wire logic       cmd_valid_i,
    input  wire iep_cmd_t   cmd_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       nack_i,
    output logic            cmd_ready_o,
    output logic            done_o,
    output logic [7:0]      rdata_o,
    output logic            ack_o
);
    iep_mst_t   st_ff;
    logic [7:0] qcnt_ff;
    logic [1:0] ph_ff;
    logic [3:0] bit_ff;
    logic [8:0] txw_ff;
    logic [8:0] rxw_ff;
    logic       scl_ff, oe_ff, ready_ff, done_ff, ack_ff;
    logic [7:0] rdata_ff;
    logic       sda_q1_ff, sda_q2_ff;

    wire tick   = (qcnt_ff == 8'(QUARTER - 1));
    wire accept = cmd_valid_i & ready_ff;
    wire last   = tick & (ph_ff == 2'h3) & ((st_ff != M_BYTE) | (bit_ff == 4'h8));

    assign link.scl      = scl_ff;
    assign link.sda_m_o  = 1'b0;
    assign link.sda_m_oe = oe_ff;
    assign cmd_ready_o   = ready_ff;
    assign done_o        = done_ff;
    assign rdata_o       = rdata_ff;
    assign ack_o         = ack_ff;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_q1_ff <= 1'b1;
            sda_q2_ff <= 1'b1;
        end else begin
            sda_q1_ff <= link.sda;
            sda_q2_ff <= sda_q1_ff;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff    <= M_IDLE;
            qcnt_ff  <= 8'h00;
            ph_ff    <= 2'h0;
            bit_ff   <= 4'h0;
            txw_ff   <= 9'h1FF;
            rxw_ff   <= 9'h000;
            scl_ff   <= 1'b1;
            oe_ff    <= 1'b0;
            ready_ff <= 1'b1;
            done_ff  <= 1'b0;
            rdata_ff <= 8'h00;
            ack_ff   <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            qcnt_ff <= (st_ff == M_IDLE || tick) ? 8'h00 : 8'(qcnt_ff + 8'h01);
            if (st_ff != M_IDLE && tick) begin
                ph_ff <= 2'(ph_ff + 2'h1);
            end
            case (st_ff)
                M_IDLE: begin
                    if (accept) begin
                        ready_ff <= 1'b0;
                        ph_ff    <= 2'h0;
                        bit_ff   <= 4'h0;
                        // ninth bit: released for our ack sample, or our ack/nack on reads
                        txw_ff   <= (cmd_i == C_READ) ? {8'hFF, nack_i} : {wdata_i, 1'b1};
                        case (cmd_i)
                            C_START: st_ff <= M_START;
                            C_STOP:  st_ff <= M_STOP;
                            default: st_ff <= M_BYTE;
                        endcase
                    end
                end
                M_START: begin
                    if (tick) begin
                        case (ph_ff)
                            2'h0:    oe_ff  <= 1'b0;
                            2'h1:    scl_ff <= 1'b1;
                            2'h2:    oe_ff  <= 1'b1;
                            default: scl_ff <= 1'b0;
                        endcase
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        case (ph_ff)
                            2'h0:    oe_ff  <= 1'b1;
                            2'h1:    scl_ff <= 1'b1;
                            2'h2:    oe_ff  <= 1'b0;
                            default: scl_ff <= 1'b1;
                        endcase
                    end
                end
                default: begin
                    if (tick) begin
                        case (ph_ff)
                            2'h0:    oe_ff  <= ~txw_ff[8];
                            2'h1:    scl_ff <= 1'b1;
                            2'h2:    rxw_ff <= {rxw_ff[7:0], sda_q2_ff};
                            default: begin
                                scl_ff <= 1'b0;
                                txw_ff <= {txw_ff[7:0], 1'b1};
                                bit_ff <= 4'(bit_ff + 4'h1);
                            end
                        endcase
                    end
                end
            endcase
            if (last) begin
                st_ff    <= M_IDLE;
                ready_ff <= 1'b1;
                done_ff  <= 1'b1;
                if (st_ff == M_BYTE) begin
                    // release sda with the falling scl so the device may drive next
                    oe_ff    <= 1'b0;
                    rdata_ff <= rxw_ff[8:1];
                    ack_ff   <= ~rxw_ff[0];
                end
            end
        end
    end
endmodule

// ===== verification/iep_link_sva.sv
// wire-level checks on the two-wire link between the master and the memory device
`timescale 1ns/1ps
`include "iep_regs.svh"
module iep_link_sva #(
    parameter int NVW_CYCLES = `IEP_NVW_TIME_NS / `IEP_CLK_NS
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    logic       scl_ff;
    logic       sda_ff;
    logic       first_ff;
    logic       alien_ff;
    logic [3:0] bit_ff;
    logic [7:0] sh_ff;
    int         since_ff;
    int         blen_ff;

    wire rise_w  = scl & ~scl_ff;
    wire start_w = scl & scl_ff & sda_ff & ~sda;
    wire stop_w  = scl & scl_ff & ~sda_ff & sda;
    wire ninth_w = rise_w & first_ff & (bit_ff == 4'h8);
    wire ours_w  = sh_ff[7:1] inside {`IEP_ADDR_AUX, `IEP_ADDR_RX1, `IEP_ADDR_RX2};

    // bit position within the first byte after each start
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_ff   <= 4'h0;
            first_ff <= 1'b0;
            alien_ff <= 1'b0;
            sh_ff    <= 8'h00;
        end else if (start_w) begin
            bit_ff   <= 4'h0;
            first_ff <= 1'b1;
            alien_ff <= 1'b0;
        end else if (rise_w) begin
            bit_ff   <= (bit_ff == 4'h9) ? 4'h1 : bit_ff + 4'h1;
            first_ff <= first_ff & (bit_ff != 4'h9);
            alien_ff <= alien_ff | (ninth_w & ~ours_w);
            sh_ff    <= {sh_ff[6:0], sda};
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_ff   <= 1'b1;
            sda_ff   <= 1'b1;
            since_ff <= 0;
            blen_ff  <= 0;
        end else begin
            scl_ff   <= scl;
            sda_ff   <= sda;
            // saturate so a long idle bus cannot wrap the count
            since_ff <= (start_w | stop_w) ? 0 : (since_ff < 1000 ? since_ff + 1 : since_ff);
            blen_ff  <= busy_o ? blen_ff + 1 : 0;
        end
    end

    sequence s_stop;
        scl && $past(scl) && !$past(sda) && sda;
    endsequence
    sequence s_own_addr;
        ninth_w && ours_w;
    endsequence

    a_scl_high_time: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase shorter than eight cycles");
    a_scl_low_time: assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low phase shorter than eight cycles");
    a_dev_sda_hold: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
        else $error("device changed sda while scl high");
    a_alien_no_ack: assert property (ninth_w && !ours_w |-> sda)
        else $error("foreign address acknowledged");
    a_alien_quiet: assert property (alien_ff |-> !sda_s_oe)
        else $error("device drove sda after foreign address");
    a_busy_refuse: assert property (s_own_addr ##0 busy_o |-> sda)
        else $error("own address acknowledged during commit");
    a_idle_own_ack: assert property (s_own_addr ##0 (!busy_o && !$past(busy_o, 16)) |-> !sda)
        else $error("own address not acknowledged while idle");
    a_busy_cause: assert property ($rose(busy_o) |-> since_ff <= 8)
        else $error("commit started without a stop or start");
    a_busy_span: assert property ($fell(busy_o) |-> blen_ff inside {[NVW_CYCLES:NVW_CYCLES + 1]})
        else $error("commit time differs from nvw count");
    a_stop_release: assert property (s_stop |-> !sda_s_oe [*4])
        else $error("device still drives sda at stop");
endmodule

// ===== verification/iep_tb_top.sv
// self-checking bench: master and memory device joined over the two-wire link
`timescale 1ns/1ps
`include "iep_regs.svh"
module iep_tb_top
    import iep_pkg::*;
;
    localparam int NVW = 400;
    logic       clk_i       = 1'b0;
    logic       reset_n_i   = 1'b0;
    logic       cmd_valid_i = 1'b0;
    iep_cmd_t   cmd_i       = C_STOP;
    logic [7:0] wdata_i     = 8'h00;
    logic       nack_i      = 1'b0;
    logic       cmd_ready_o, done_o, ack_o, busy_o, shadow_on_o, mask_on_o;
    logic [7:0] rdata_o;
    int         mismatches  = 0;
    int         n_compared  = 0;

    always #20 clk_i = ~clk_i;

    iep_link_if link ();
    iep_slave #(.NVW_CYCLES(NVW)) iep_slave_inst (.clk_i, .reset_n_i, .link(link.slave),
        .busy_o, .shadow_on_o, .mask_on_o);
    iep_master iep_master_inst (.clk_i, .reset_n_i, .link(link.master), .cmd_valid_i, .cmd_i,
        .wdata_i, .nack_i, .cmd_ready_o, .done_o, .rdata_o, .ack_o);
    iep_link_sva #(.NVW_CYCLES(NVW)) iep_link_sva_inst (.clk_i, .reset_n_i, .scl(link.scl),
        .sda(link.sda), .sda_s_oe(link.sda_s_oe), .busy_o);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic reset_dut();
        @(negedge clk_i);
        reset_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        reset_n_i = 1'b1;
    endtask

    task automatic op(input iep_cmd_t c, input logic [7:0] d, input logic n);
        int i;
        @(negedge clk_i);
        cmd_i = c;
        wdata_i = d;
        nack_i = n;
        cmd_valid_i = 1'b1;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        for (i = 0; i < 300 && done_o !== 1'b1; i++) @(negedge clk_i);
        // ready must be back with the done pulse, or back-to-back commands stall
        if (done_o !== 1'b1 || cmd_ready_o !== 1'b1) mismatches++;
    endtask

    task automatic wb(input logic [7:0] d, input logic exp_ack);
        op(C_WRITE, d, 1'b0);
        check({7'h00, ack_o}, {7'h00, exp_ack});
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] m, input logic [7:0] q[$]);
        op(C_START, 8'h00, 1'b0);
        wb({a, 1'b0}, 1'b1);
        wb(m, 1'b1);
        foreach (q[i]) wb(q[i], 1'b1);
        op(C_STOP, 8'h00, 1'b0);
    endtask

    task automatic cur(input logic [6:0] a, input logic [7:0] q[$]);
        op(C_START, 8'h00, 1'b0);
        wb({a, 1'b1}, 1'b1);
        foreach (q[i]) begin
            op(C_READ, 8'h00, i == q.size() - 1);
            check(rdata_o, q[i]);
        end
        op(C_STOP, 8'h00, 1'b0);
    endtask

    // dummy write of the memory address, then a repeated start into the read
    task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] q[$]);
        op(C_START, 8'h00, 1'b0);
        wb({a, 1'b0}, 1'b1);
        wb(m, 1'b1);
        cur(a, q);
    endtask

    // acknowledge polling; the first probe shows whether a commit is running
    task automatic poll(input logic first_ack);
        int   k;
        logic got;
        got = 1'b0;
        for (k = 0; k < 8 && !got; k++) begin
            op(C_START, 8'h00, 1'b0);
            op(C_WRITE, {`IEP_ADDR_RX1, 1'b0}, 1'b0);
            got = ack_o;
            if (k == 0) check({7'h00, ack_o}, {7'h00, first_ack});
            op(C_STOP, 8'h00, 1'b0);
        end
        check({7'h00, got}, 8'h01);
    endtask

    task automatic t_row_wrap();
        wr(`IEP_ADDR_RX1, 8'h00, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7});
        poll(1'b0);
        wr(`IEP_ADDR_RX1, 8'h06, '{8'h11, 8'h22, 8'h33});
        poll(1'b0);
        rd(`IEP_ADDR_RX1, 8'h00, '{8'h33, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'h11});
        cur(`IEP_ADDR_RX1, '{8'h22});
    endtask

    task automatic t_foreign();
        op(C_START, 8'h00, 1'b0);
        wb({7'h52, 1'b0}, 1'b0);
        wb(8'h00, 1'b0);
        wb(8'hEE, 1'b0);
        op(C_STOP, 8'h00, 1'b0);
        rd(`IEP_ADDR_RX1, 8'h00, '{8'h33});
    endtask

    task automatic t_spaces();
        wr(`IEP_ADDR_AUX, 8'hF8, '{8'h5C});
        poll(1'b0);
        rd(`IEP_ADDR_AUX, 8'hF8, '{8'h5C});
        wr(`IEP_ADDR_RX1, 8'h7F, '{8'h06});
        poll(1'b0);
        rd(`IEP_ADDR_RX1, 8'h80, '{8'h00});
    endtask

    task automatic t_shadow();
        wr(`IEP_ADDR_RX1, 8'h20, '{8'h5A});
        poll(1'b0);
        wr(`IEP_ADDR_RX1, 8'h7F, '{8'h02});
        poll(1'b0);
        wr(`IEP_ADDR_RX1, 8'h80, '{8'h01});
        poll(1'b0);
        check({7'h00, shadow_on_o}, 8'h01);
        wr(`IEP_ADDR_RX1, 8'h20, '{8'hC3});
        poll(1'b1);
        rd(`IEP_ADDR_RX1, 8'h20, '{8'hC3});
        reset_dut();
        rd(`IEP_ADDR_RX1, 8'h20, '{8'h5A});
    endtask

    // mask bit moves the enable row of table 01h into table 05h
    task automatic t_mask();
        wr(`IEP_ADDR_RX1, 8'h88, '{8'h01});
        poll(1'b0);
        check({7'h00, mask_on_o}, 8'h01);
        wr(`IEP_ADDR_RX1, 8'h7F, '{8'h01});
        poll(1'b1);
        rd(`IEP_ADDR_RX1, 8'hF8, '{8'h00});
        wr(`IEP_ADDR_RX1, 8'h7F, '{8'h05});
        poll(1'b1);
        wr(`IEP_ADDR_RX1, 8'hF8, '{8'h77});
        poll(1'b0);
        rd(`IEP_ADDR_RX1, 8'hF8, '{8'h77});
        rd(`IEP_ADDR_RX1, 8'hF0, '{8'h00});
    endtask

    // receiver 2 keeps its own lower memory apart from receiver 1
    task automatic t_rx2();
        wr(`IEP_ADDR_RX2, 8'h20, '{8'h9E});
        poll(1'b1);
        rd(`IEP_ADDR_RX2, 8'h20, '{8'h9E});
        rd(`IEP_ADDR_RX1, 8'h20, '{8'h5A});
    endtask

    initial begin
        reset_dut();
        t_row_wrap();
        t_foreign();
        t_spaces();
        t_shadow();
        t_mask();
        t_rx2();
        final_report();
    end

    // the whole sequence needs roughly 22k cycles
    initial begin
        #(40 * 60000);
        mismatches++;
        final_report();
    end
endmodule
